// ===== gam_pkg.sv
/*
  Constants, types and register map for the pin alternate function mux.
  Assumes one core clock, an active-high asynchronous reset and a plain
  strobe-style register port driven from the same clock domain.
*/
// Functional notes
// - each pin chooses general-purpose I/O or peripheral operation per port
// - in peripheral operation the peripheral, not direction bits, sets enable
// - multi-function pins pick their function from the set-select bits
// - crystal enabled: port A bits 0 and 1 leave GPIO for the crystal
// - port C bits 0,1: select bit one routes to analog/comparator input
// - port C bit 2: select bit one routes to analog input or reference
// - ports B and C use select register 1 only, and need the enable
// - port D bit 0 only has external reset; enable selects it directly
// - port A pins have one function each; enable activates it directly
// - port A bits 0 and 6 follow timer configuration for direction
// - reference sits on port B bit 5 (28-pin) or port C bit 2 (20-pin)
`default_nettype none

package gam_pkg;

  // geometry
  localparam int NPORT = 4;
  localparam int NBIT = 8;
  localparam int NPIN = 32;
  localparam int AW = 5;

  // port numbers, the upper two address bits
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;

  // register select, the lower three address bits
  localparam logic [2:0] REG_DATA_OUT = 3'h0;
  localparam logic [2:0] REG_DIR = 3'h1;
  localparam logic [2:0] REG_ALT_EN = 3'h2;
  localparam logic [2:0] REG_FSS1 = 3'h3;
  localparam logic [2:0] REG_FSS2 = 3'h4;
  localparam logic [2:0] REG_DATA_IN = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // field positions
  localparam int BIT_XTAL_IN = 0;
  localparam int BIT_XTAL_OUT = 1;
  localparam int BIT_TMR_A0 = 0;
  localparam int BIT_TMR_A6 = 6;
  localparam int BIT_VREF_B = 5;
  localparam int BIT_ANA4 = 0;
  localparam int BIT_ANA5 = 1;
  localparam int BIT_ANALOG_IN6 = 2;
  localparam int BIT_COMPARATOR_OUTPUT = 3;
  localparam int BIT_EXT_RESET = 0;
  localparam int STAT_XTAL = 0;
  localparam int STAT_PKG28 = 1;

  // one peripheral request for a pin
  typedef struct packed {
    logic out;
    logic oe;
  } gam_req_s;

  // how a pin is handed out
  typedef enum logic [1:0] {
    MODE_GPIO = 2'b00,
    MODE_ALT0 = 2'b01,
    MODE_ALT1 = 2'b10,
    MODE_PARK = 2'b11
  } gam_mode_e;

endpackage : gam_pkg

`default_nettype wire

// ===== gam_pin_cell.sv
/*
  One pin's output stage and input gate.
  Assumes the pin level arrives already synchronised and that the mode is
  decoded by the caller on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gam_pin_cell (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire gam_pkg::gam_mode_e mode, // decoded pin mode
  input wire logic gpio_out, // port data output bit
  input wire logic gpio_dir, // port direction bit, 1 drives
  input wire gam_pkg::gam_req_s req0, // first peripheral request
  input wire gam_pkg::gam_req_s req1, // second peripheral request
  input wire logic pin_sync, // synchronised pin level
  output logic pin_out, // pad output value
  output logic pin_oe, // pad output enable
  output logic periph_in // pin level seen by the peripheral
);

  logic out_next;
  logic oe_next;
  logic in_next;

  // choose the driver of the pad
  always_comb begin
    out_next = 1'b0;
    oe_next = 1'b0;
    in_next = 1'b0;
    unique case (mode)
      gam_pkg::MODE_GPIO: begin
        out_next = gpio_out;
        oe_next = gpio_dir;
      end
      gam_pkg::MODE_ALT0: begin
        out_next = req0.out;
        oe_next = req0.oe;
        in_next = pin_sync;
      end
      gam_pkg::MODE_ALT1: begin
        out_next = req1.out;
        oe_next = req1.oe;
        in_next = pin_sync;
      end
      gam_pkg::MODE_PARK: begin
        // digital side released; analog, crystal or nothing owns the pad
        out_next = 1'b0;
        oe_next = 1'b0;
      end
    endcase
  end

  // registered pad and peripheral signals
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      periph_in <= 1'b0;
    end else begin
      pin_out <= out_next;
      pin_oe <= oe_next;
      periph_in <= in_next; // peripherals see nothing unless they own it
    end
  end

endmodule : gam_pin_cell

`default_nettype wire

// ===== gam_mux.sv
/*
  Alternate function mux for four 8-bit general-purpose ports.
  Holds the port data, direction, enable and set-select registers behind a
  plain strobe port, decodes each pin's mode and drives the pads.
  Assumes peripherals, the oscillator control and the timer deliver their
  requests on core_clk; pads and the package strap are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module gam_mux (
  input wire logic core_clk, // system clock, 10 MHz
  input wire logic rst, // async reset, active high
  input wire logic [gam_pkg::AW-1:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic [gam_pkg::NPIN-1:0] pin_in, // pad input levels
  output logic [gam_pkg::NPIN-1:0] pin_out, // pad output values
  output logic [gam_pkg::NPIN-1:0] pin_oe, // pad output enables
  input wire gam_pkg::gam_req_s [gam_pkg::NPIN-1:0] alt_req0, // function 0
  input wire gam_pkg::gam_req_s [gam_pkg::NPIN-1:0] alt_req1, // function 1
  output logic [gam_pkg::NPIN-1:0] periph_in, // pin levels to peripherals
  input wire logic xtal_en, // crystal oscillator enabled
  input wire logic timer_a0_is_output, // timer drives complement on a0
  input wire logic timer_a6_is_output, // timer drives complement on a6
  input wire logic pkg_28pin, // package strap, 1 for 28-pin
  output logic xtal_sel, // port a bits 0,1 handed to crystal
  output logic analog_in4_comp_pos_sel, // port c bit 0 analog
  output logic analog_in5_comp_neg_sel, // port c bit 1 analog
  output logic analog_in6_sel, // port c bit 2 analog input
  output logic adc_vref_sel, // reference pin routed
  output logic comparator_output_sel, // port c bit 3 comparator out
  output logic ext_reset_sel // port d bit 0 external reset
);

  // software-visible state, one byte per port
  logic [7:0] data_out_reg [gam_pkg::NPORT];
  logic [7:0] dir_reg [gam_pkg::NPORT];
  logic [7:0] alt_en_reg [gam_pkg::NPORT];
  logic [7:0] fss1_reg [gam_pkg::NPORT];
  logic [7:0] fss2_reg [gam_pkg::NPORT];

  // pad synchronisers; stage one is read only by stage two
  logic [gam_pkg::NPIN-1:0] pin_meta_reg;
  logic [gam_pkg::NPIN-1:0] pin_sync_reg;
  logic pkg_meta_reg;
  logic pkg_sync_reg;

  // decoded modes and adjusted requests
  gam_pkg::gam_mode_e mode [gam_pkg::NPIN];
  gam_pkg::gam_req_s req0_eff [gam_pkg::NPIN];
  logic [7:0] rdata_next;
  logic vref_next;
  logic ana4_next;
  logic ana5_next;
  logic analog_in6_next;
  logic comparator_output_next;
  logic ext_reset_next;

  // only ports b and c own set-select registers
  function automatic logic has_select(input logic [1:0] port);
    has_select = (port == gam_pkg::PORT_B) || (port == gam_pkg::PORT_C);
  endfunction : has_select

  // which port an access names
  function automatic logic [1:0] addr_port(
    input logic [gam_pkg::AW-1:0] addr
  );
    addr_port = addr[4:3];
  endfunction : addr_port

  // which register of the addressed port an access names
  function automatic logic reg_is(
    input logic [gam_pkg::AW-1:0] addr,
    input logic [2:0] idx
  );
    reg_is = (addr[2:0] == idx);
  endfunction : reg_is

  // an analog or reference route needs both the enable and the select bit;
  // a select bit alone must not pull a pin away from its port
  function automatic logic routed(
    input logic [7:0] en,
    input logic [7:0] fs,
    input int bitn
  );
    routed = en[bitn] && fs[bitn];
  endfunction : routed

  // decode one pin's mode from its port settings
  function automatic gam_pkg::gam_mode_e pin_mode(
    input logic [1:0] port,
    input int bitn,
    input logic af,
    input logic fs1,
    input logic xtal,
    input logic pkg28
  );
    pin_mode = gam_pkg::MODE_GPIO;
    if (xtal && (port == gam_pkg::PORT_A) &&
        ((bitn == gam_pkg::BIT_XTAL_IN) ||
         (bitn == gam_pkg::BIT_XTAL_OUT))) begin
      pin_mode = gam_pkg::MODE_PARK;
    end else if (!af) begin
      pin_mode = gam_pkg::MODE_GPIO;
    end else begin
      unique case (port)
        gam_pkg::PORT_A: begin
          pin_mode = gam_pkg::MODE_ALT0;
        end
        gam_pkg::PORT_B: begin
          if (fs1 && pkg28 && (bitn == gam_pkg::BIT_VREF_B)) begin
            pin_mode = gam_pkg::MODE_PARK;
          end else begin
            pin_mode = fs1 ? gam_pkg::MODE_ALT1
                           : gam_pkg::MODE_ALT0;
          end
        end
        gam_pkg::PORT_C: begin
          if (bitn == gam_pkg::BIT_COMPARATOR_OUTPUT) begin
            // comparator output on zero, reserved on one
            pin_mode = fs1 ? gam_pkg::MODE_PARK
                           : gam_pkg::MODE_ALT0;
          end else begin
            // analog, reserved or unassigned: digital side stays off
            pin_mode = gam_pkg::MODE_PARK;
          end
        end
        gam_pkg::PORT_D: begin
          pin_mode = (bitn == gam_pkg::BIT_EXT_RESET)
                   ? gam_pkg::MODE_ALT0
                   : gam_pkg::MODE_PARK;
        end
      endcase
    end
  endfunction : pin_mode

  // register writes, one block per port
  genvar gp;
  generate
    for (gp = 0; gp < gam_pkg::NPORT; gp++) begin : g_port
      localparam logic [1:0] PNUM = 2'(gp);
      logic hit;
      assign hit = reg_wr && (addr_port(reg_addr) == PNUM);

      // port data output bits, driven onto pads in gpio mode
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          data_out_reg[gp] <= gam_pkg::RST_BYTE;
        end else if (hit && reg_is(reg_addr, gam_pkg::REG_DATA_OUT)) begin
          data_out_reg[gp] <= reg_wdata;
        end
      end

      // port direction bits, 1 drives the pad in gpio mode
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          dir_reg[gp] <= gam_pkg::RST_BYTE;
        end else if (hit && reg_is(reg_addr, gam_pkg::REG_DIR)) begin
          dir_reg[gp] <= reg_wdata;
        end
      end

      // alternate function enables; a clear bit hands the pin to the port
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          alt_en_reg[gp] <= gam_pkg::RST_BYTE;
        end else if (hit && reg_is(reg_addr, gam_pkg::REG_ALT_EN)) begin
          alt_en_reg[gp] <= reg_wdata;
        end
      end

      // set-select registers exist only where a pin has two choices;
      // elsewhere writes are dropped and reads give zero
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          fss1_reg[gp] <= gam_pkg::RST_BYTE;
        end else if (hit && has_select(PNUM) &&
                     reg_is(reg_addr, gam_pkg::REG_FSS1)) begin
          fss1_reg[gp] <= reg_wdata;
        end
      end

      // second set register: stored for software, never steers a pin
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          fss2_reg[gp] <= gam_pkg::RST_BYTE;
        end else if (hit && has_select(PNUM) &&
                     reg_is(reg_addr, gam_pkg::REG_FSS2)) begin
          fss2_reg[gp] <= reg_wdata;
        end
      end
    end
  endgenerate

  // two-flop synchronisers on the pads
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // the package strap reads as 20-pin until two edges after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pkg_meta_reg <= 1'b0;
      pkg_sync_reg <= 1'b0;
    end else begin
      pkg_meta_reg <= pkg_28pin;
      pkg_sync_reg <= pkg_meta_reg;
    end
  end

  // per-pin decode and output stage
  genvar gi;
  generate
    for (gi = 0; gi < gam_pkg::NPIN; gi++) begin : g_pin
      localparam int PORT = gi / gam_pkg::NBIT;
      localparam int BITN = gi % gam_pkg::NBIT;
      localparam logic [1:0] PNUM = 2'(PORT);
      localparam bit TMR_PIN = (PORT == 0) &&
        ((BITN == gam_pkg::BIT_TMR_A0) || (BITN == gam_pkg::BIT_TMR_A6));
      localparam bit IS_A0 = (BITN == gam_pkg::BIT_TMR_A0);

      assign mode[gi] = pin_mode(PNUM, BITN, alt_en_reg[PORT][BITN],
                                 fss1_reg[PORT][BITN], xtal_en,
                                 pkg_sync_reg);

      // timer pins take direction from the timer's current setup
      always_comb begin
        req0_eff[gi] = alt_req0[gi];
        if (TMR_PIN) begin
          req0_eff[gi].oe = IS_A0 ? timer_a0_is_output
                                  : timer_a6_is_output;
        end
      end

      gam_pin_cell u_cell (
        .core_clk(core_clk),
        .rst(rst),
        .mode(mode[gi]),
        .gpio_out(data_out_reg[PORT][BITN]),
        .gpio_dir(dir_reg[PORT][BITN]),
        .req0(req0_eff[gi]),
        .req1(alt_req1[gi]),
        .pin_sync(pin_sync_reg[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi]),
        .periph_in(periph_in[gi])
      );
    end
  endgenerate

  // reference lands on a different pin per package
  always_comb begin
    if (pkg_sync_reg) begin
      vref_next = routed(alt_en_reg[1], fss1_reg[1],
                         gam_pkg::BIT_VREF_B);
    end else begin
      vref_next = routed(alt_en_reg[2], fss1_reg[2],
                         gam_pkg::BIT_ANALOG_IN6);
    end
  end

  // routing flags ahead of their output flops
  always_comb begin
    ana4_next = routed(alt_en_reg[2], fss1_reg[2],
                       gam_pkg::BIT_ANA4);
    ana5_next = routed(alt_en_reg[2], fss1_reg[2],
                       gam_pkg::BIT_ANA5);
    // in 20-pin parts the same pin may serve as input or reference
    analog_in6_next = routed(alt_en_reg[2], fss1_reg[2],
                       gam_pkg::BIT_ANALOG_IN6);
    comparator_output_next = (mode[8*2 + gam_pkg::BIT_COMPARATOR_OUTPUT] ==
                 gam_pkg::MODE_ALT0);
    ext_reset_next = (mode[8*3 + gam_pkg::BIT_EXT_RESET] ==
                      gam_pkg::MODE_ALT0);
  end

  // crystal hand-over flag for the oscillator control
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xtal_sel <= 1'b0;
    end else begin
      xtal_sel <= xtal_en;
    end
  end

  // analog and reference routing flags for converter and comparator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      analog_in4_comp_pos_sel <= 1'b0;
      analog_in5_comp_neg_sel <= 1'b0;
      analog_in6_sel <= 1'b0;
      adc_vref_sel <= 1'b0;
    end else begin
      analog_in4_comp_pos_sel <= ana4_next;
      analog_in5_comp_neg_sel <= ana5_next;
      analog_in6_sel <= analog_in6_next;
      adc_vref_sel <= vref_next;
    end
  end

  // digital function flags for the comparator output and reset pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      comparator_output_sel <= 1'b0;
      ext_reset_sel <= 1'b0;
    end else begin
      comparator_output_sel <= comparator_output_next;
      ext_reset_sel <= ext_reset_next;
    end
  end

  // read decode; unmapped and absent registers read zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr[2:0])
      gam_pkg::REG_DATA_OUT: rdata_next = data_out_reg[addr_port(reg_addr)];
      gam_pkg::REG_DIR: rdata_next = dir_reg[addr_port(reg_addr)];
      gam_pkg::REG_ALT_EN: rdata_next = alt_en_reg[addr_port(reg_addr)];
      gam_pkg::REG_FSS1: rdata_next = fss1_reg[addr_port(reg_addr)];
      gam_pkg::REG_FSS2: rdata_next = fss2_reg[addr_port(reg_addr)];
      gam_pkg::REG_DATA_IN: begin
        // port input is read through the synchroniser in every mode
        rdata_next = pin_sync_reg[8*addr_port(reg_addr) +: 8];
      end
      gam_pkg::REG_STATUS: begin
        rdata_next[gam_pkg::STAT_XTAL] = xtal_en;
        rdata_next[gam_pkg::STAT_PKG28] = pkg_sync_reg;
      end
      default: rdata_next = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

endmodule : gam_mux

`default_nettype wire

// ===== gam_mux_monitor.sv
/*
  Port checker for the pin alternate function mux.
  Assumes it is bound to gam_mux and that all signals share core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gam_mux_monitor (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [gam_pkg::AW-1:0] reg_addr, // register index
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [gam_pkg::NPIN-1:0] pin_oe, // pad enables
  input wire logic xtal_en, // crystal enabled
  input wire logic pkg_28pin, // package strap
  input wire logic xtal_sel, // crystal owns a0/a1
  input wire logic analog_in4_comp_pos_sel, // c0 analog
  input wire logic analog_in5_comp_neg_sel, // c1 analog
  input wire logic analog_in6_sel, // c2 analog
  input wire logic adc_vref_sel // reference routed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // strap is synced and the crystal flag is registered, so both are held a few cycles first
  sequence xtal_held;
    xtal_en [*3];
  endsequence
  sequence rd_status;
    reg_rd && reg_addr[2:0] == 3'h6;
  endsequence

  xtal_sel_a: assert property ($rose(xtal_en) |-> ##[1:3] xtal_sel)
    else $error("crystal select late");
  xtal_park_a: assert property (xtal_held |-> pin_oe[1:0] == 2'h0)
    else $error("crystal pins still driven");
  xtal_status_a: assert property (
    xtal_held ##0 rd_status |=> reg_rdata[0])
    else $error("status misses crystal");
  no_select_a: assert property (
    reg_rd && (reg_addr[2:0] == 3'h7 ||
    (reg_addr[2:0] inside {3'h3, 3'h4} && !(^reg_addr[4:3])))
    |=> reg_rdata == 8'h00)
    else $error("absent register read nonzero");
  ana4_release_a: assert property (
    analog_in4_comp_pos_sel [*3] |-> !pin_oe[16])
    else $error("c0 driven while analog");
  ana5_release_a: assert property (
    analog_in5_comp_neg_sel [*3] |-> !pin_oe[17])
    else $error("c1 driven while analog");
  analog_in6_release_a: assert property (
    analog_in6_sel [*3] |-> !pin_oe[18])
    else $error("c2 driven while analog");
  vref_small_a: assert property (
    !pkg_28pin [*4] |-> adc_vref_sel == analog_in6_sel)
    else $error("reference not on c2");
endmodule : gam_mux_monitor

bind gam_mux gam_mux_monitor gam_mux_monitor_i (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_oe(pin_oe),
  .xtal_en(xtal_en), .pkg_28pin(pkg_28pin), .xtal_sel(xtal_sel),
  .analog_in4_comp_pos_sel(analog_in4_comp_pos_sel),
  .analog_in5_comp_neg_sel(analog_in5_comp_neg_sel),
  .analog_in6_sel(analog_in6_sel), .adc_vref_sel(adc_vref_sel));

`default_nettype wire

// ===== gam_periph_model.sv
/*
  Behavioural peripherals requesting every pin.
  Assumes the same core_clk and reset as the mux.
*/
`timescale 1ns/1ps
`default_nettype none

module gam_periph_model (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  output var gam_pkg::gam_req_s [31:0] alt_req0, // function 0 requests
  output var gam_pkg::gam_req_s [31:0] alt_req1 // function 1 requests
);
  logic [63:0] st_reg;

  // requests move every cycle, also on pins not handed over, so the
  // mux must ignore them wherever the enable is clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= 64'h0123456789abcdef;
    end else begin
      st_reg <= st_reg * 64'h5851f42d4c957f2d + 64'h1;
    end
  end

  assign alt_req0 = st_reg;
  assign alt_req1 = {st_reg[31:0], ~st_reg[63:32]};
endmodule : gam_periph_model

`default_nettype wire

// ===== gam_mux_tb.sv
/*
  Self-checking bench for the pin alternate function mux.
  Assumes gam_mux, gam_periph_model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none

module gam_mux_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] pin_in = 32'h0, pin_out, pin_oe, periph_in;
  gam_pkg::gam_req_s [31:0] alt_req0, alt_req1, r0, r1;
  logic xtal_en = 1'b0, t0 = 1'b0, t6 = 1'b0, pkg = 1'b0;
  wire [6:0] sel;
  logic [31:0] seed = 32'hdb45b5e7;
  logic [7:0] cfg [4][5] = '{default: 8'h00}; // shadow of writes
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;

  gam_mux gam_mux_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_req0(alt_req0), .alt_req1(alt_req1),
    .periph_in(periph_in), .xtal_en(xtal_en), .timer_a0_is_output(t0),
    .timer_a6_is_output(t6), .pkg_28pin(pkg), .xtal_sel(sel[0]),
    .analog_in4_comp_pos_sel(sel[1]), .analog_in5_comp_neg_sel(sel[2]),
    .analog_in6_sel(sel[3]), .adc_vref_sel(sel[4]),
    .comparator_output_sel(sel[5]), .ext_reset_sel(sel[6]));
  gam_periph_model gam_periph_model_i (.core_clk(core_clk), .rst(rst),
    .alt_req0(alt_req0), .alt_req1(alt_req1));

  // clock, 100 ns period
  always #50 core_clk = ~core_clk;

  // hang guard, well above the roughly 1300 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      $display("MISMATCH %0t timeout", $time);
      print_verdict();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction : nxt

  function automatic logic [7:0] rnd();
    seed = nxt(seed);
    return seed[7:0];
  endfunction : rnd

  // 0 gpio, 1 first function, 2 second function, 3 parked
  function automatic logic [1:0] mode(input int p, input int b);
    logic fs;
    fs = cfg[p][3][b];
    if (p == 0 && b < 2 && xtal_en) return 2'h3;
    if (!cfg[p][2][b]) return 2'h0;
    case (p)
      0: return 2'h1;
      1: return !fs ? 2'h1 : (b == 5 && pkg) ? 2'h3 : 2'h2;
      2: return (b == 3 && !fs) ? 2'h1 : 2'h3;
      default: return (b == 0) ? 2'h1 : 2'h3;
    endcase
  endfunction : mode

  function automatic logic [7:0] reg_exp(input int p, input int r);
    if (r == 5) return pin_in[p*8 +: 8];
    if (r == 6) return {6'h00, pkg, xtal_en};
    if (r == 7 || (r > 2 && (p == 0 || p == 3))) return 8'h00;
    return cfg[p][r];
  endfunction : reg_exp

  function automatic logic [6:0] sel_exp();
    logic [7:0] c;
    c = cfg[2][2] & cfg[2][3];
    return {cfg[3][2][0], cfg[2][2][3] & ~cfg[2][3][3],
      pkg ? cfg[1][2][5] & cfg[1][3][5] : c[2], c[2], c[1], c[0], xtal_en};
  endfunction : sel_exp

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
    input logic [31:0] m);
    samples_checked++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("MISMATCH %0t pins got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic wr(input int p, input int r, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= {p[1:0], r[2:0]};
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (r < 5) cfg[p][r] = d;
  endtask : wr

  task automatic rd(input int p, input int r);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= {p[1:0], r[2:0]};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    cmp_reg(reg_rdata, reg_exp(p, r));
  endtask : rd

  // requests caught at one falling edge show on the pads at the next
  task automatic run_pins();
    logic [31:0] eo, ee, ep, m;
    logic [1:0] md;
    gam_pkg::gam_req_s q;
    @(negedge core_clk);
    r0 = alt_req0;
    r1 = alt_req1;
    repeat (4) begin
      @(negedge core_clk);
      for (int i = 0; i < 32; i++) begin
        md = mode(i / 8, i % 8);
        q = (md == 2'h2) ? r1[i] : r0[i];
        if (md == 2'h1 && i == 0) q.oe = t0;
        if (md == 2'h1 && i == 6) q.oe = t6;
        m[i] = (md != 2'h3);
        eo[i] = (md == 2'h0) ? cfg[i/8][0][i%8] : q.out;
        ee[i] = (md == 2'h0) ? cfg[i/8][1][i%8] : m[i] & q.oe;
        ep[i] = (md == 2'h1 || md == 2'h2) & pin_in[i];
      end
      cmp(pin_out, eo, m);
      cmp(pin_oe, ee, 32'hffffffff);
      cmp(periph_in, ep, 32'hffffffff);
      cmp({25'h0, sel}, {25'h0, sel_exp()}, 32'hffffffff);
      r0 = alt_req0;
      r1 = alt_req1;
    end
  endtask : run_pins

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // reset values, read-back with refused writes, then random configurations
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a++) rd(a / 8, a % 8);
    $display("test reset_values done");
    for (int a = 0; a < 32; a++) begin
      wr(a / 8, a % 8, rnd());
      rd(a / 8, a % 8);
    end
    $display("test readback done");
    for (int i = 0; i < 24; i++) begin
      seed = nxt(seed);
      @(posedge core_clk);
      xtal_en <= (i < 4) ? i[1] : seed[0];
      pkg <= (i < 4) ? i[0] : seed[1];
      t0 <= seed[2];
      t6 <= seed[3];
      pin_in <= nxt(seed);
      for (int p = 0; p < 4; p++) begin
        wr(p, 0, rnd());
        wr(p, 1, rnd());
        wr(p, 2, (i < 4) ? 8'hff : rnd());
        wr(p, 3, (i < 4) ? {8{i[0]}} : rnd());
      end
      repeat (4) @(posedge core_clk);
      run_pins();
      rd(0, 6);
      rd(i % 4, 5);
      $display("test config %0d done", i);
    end
    print_verdict();
  end
endmodule : gam_mux_tb

`default_nettype wire
